// *** shared/tmrb_pkg.sv ***
// constants, types and field layout of the temperature monitor register bank
// Summary of operation
// R01: result registers written only by converter
// R02: status bit 7 shows conversion busy
// R03: status bit 6 local above high limit
// R04: status bit 5 local below low limit
// R05: status bit 4 remote above high limit
// R06: status bit 3 remote below low limit
// R07: status bit 2 remote sensor open; 1:0 zero
// R08: any flag high sets alert latch
// R09: status read clears flags whose cause went
// R10: flag holds while its cause persists
// R11: alert latch cleared by alert response only
// R12: limits, config, rate use separate read/write addresses
// R13: one-shot write starts one cycle, data dropped
// R14: config bit 6 selects run or standby
// R15: low standby pin forces standby
// R16: standby keeps last measured results
// R17: config bit 7 masks alert output
// R18: rate code divides period, 16 s to 125 ms
// R19: host writes rate upper bits as zero
// R20: strict greater or strict less comparisons
// R21: power-on defaults of results, rate, limits
// R22: limits compare as signed values
// R23: first write byte loads address pointer
// R24: host writes one or two bytes, reads one
// R25: wrong-direction address gives invalid result
// R26: signed offset added to remote result
// R27: reserved addresses read zero, writes ignored
package tmrb_pkg;

    // read addresses
    localparam logic [7:0] RD_LOCAL  = 8'h00;
    localparam logic [7:0] RD_REMOTE = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CFG    = 8'h03;
    localparam logic [7:0] RD_RATE   = 8'h04;
    localparam logic [7:0] RD_LIMIT0 = 8'h05; // first of four limits
    localparam logic [7:0] RD_MAKER  = 8'hFE;
    localparam logic [7:0] RD_REV    = 8'hFF;
    // write addresses
    localparam logic [7:0] WR_CFG    = 8'h09;
    localparam logic [7:0] WR_RATE   = 8'h0A;
    localparam logic [7:0] WR_LIMIT0 = 8'h0B; // first of four limits
    localparam logic [7:0] WR_SHOT   = 8'h0F;
    localparam logic [7:0] ADDR_OFS  = 8'h11; // same for both directions

    // status bit positions
    localparam int ST_BUSY     = 7;
    localparam int ST_LOC_OVER = 6;
    localparam int ST_LOC_UND  = 5;
    localparam int ST_REM_OVER = 4;
    localparam int ST_REM_UND  = 3;
    localparam int ST_OPEN     = 2;
    // configuration bit positions
    localparam int CFG_MASK    = 7;
    localparam int CFG_STOP    = 6;

    // power-on values
    localparam logic [7:0] TEMP_RST = 8'h80;
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] HI_RST   = 8'h7F;
    localparam logic [7:0] LO_RST   = 8'hC9;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] OFS_RST  = 8'h00;
    localparam logic [7:0] PTR_RST  = 8'h00;

    // identity bytes, values arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5A;
    localparam logic [7:0] REV_ID   = 8'h01;

    // timing
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned FAST_PERIOD_MS = 125;
    localparam logic [2:0]  RATE_MAX_CODE  = 3'h7;

    // one converter result
    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_temp;
        logic       remote_open;
    } tmrb_conv_t;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_EVAL = 3'b100
    } tmrb_state_t;

endpackage : tmrb_pkg

// *** rtl/tmrb_core.sv ***
// register bank, conversion sequencer and alarm logic of the monitor
module tmrb_core #(
    // cycles of the fastest conversion period, shortened in simulation
    parameter int unsigned FAST_PERIOD_CYC =
        tmrb_pkg::FAST_PERIOD_MS * 1000 * tmrb_pkg::CLK_MHZ
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // byte level side of the serial slave
    input  wire logic               wr_byte_i,
    input  wire logic               wr_first_i,
    input  wire logic [7:0]         wr_data_i,
    input  wire logic               rd_req_i,
    input  wire logic               ara_i,
    output logic      [7:0]         rd_data_o,
    output logic                    rd_valid_o,
    // converter side
    output logic                    conv_start_o,
    input  wire logic               conv_done_i,
    input  wire tmrb_pkg::tmrb_conv_t conv_res_i,
    // pins
    input  wire logic               standby_pin_n_i,
    output logic                    alert_n_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    tmrb_pkg::tmrb_state_t state_reg;    // sequencer state
    tmrb_pkg::tmrb_state_t state_next;
    logic [7:0]  ptr_reg;                // address pointer
    logic [7:0]  cfg_reg;                // configuration
    logic [7:0]  rate_reg;               // conversion rate code
    logic [7:0]  ofs_reg;                // remote offset
    logic [7:0]  loc_reg;                // local result
    logic [7:0]  rem_reg;                // remote result
    logic        open_reg;               // remote sensor open
    logic [7:0]  lim_reg [4];            // hi/lo local, hi/lo remote
    logic [4:0]  flag_reg;               // sticky flags, bit4 = over
    logic [4:0]  flag_next;
    logic        latch_reg;              // alert latch
    logic        latch_next;
    logic [31:0] timer_reg;              // period countdown
    logic        boot_reg;               // first pass after reset
    logic        shot_pend_reg;          // one-shot request waiting
    logic        shot_run_reg;           // current pass is one-shot
    logic        sb_s1_reg;              // standby pin synchroniser
    logic        sb_s2_reg;
    logic        sb_s3_reg;
    logic        sb_lvl_reg;             // filtered pin level
    logic [7:0]  rd_mux;                 // read data selection

    // ---------------------------------------------------------------
    // decodes
    // ---------------------------------------------------------------
    // pointer load vs data byte
    wire ptr_load  = wr_byte_i & wr_first_i;                   // R23
    wire data_wr   = wr_byte_i & ~wr_first_i;                  // R23
    wire wr_cfg    = data_wr & (ptr_reg == tmrb_pkg::WR_CFG);  // R12
    wire wr_rate   = data_wr & (ptr_reg == tmrb_pkg::WR_RATE); // R12
    wire wr_ofs    = data_wr & (ptr_reg == tmrb_pkg::ADDR_OFS);// R26
    wire wr_shot   = data_wr & (ptr_reg == tmrb_pkg::WR_SHOT); // R13
    wire rd_status = rd_req_i & (ptr_reg == tmrb_pkg::RD_STATUS);

    // standby from bit or pin
    wire standby = cfg_reg[tmrb_pkg::CFG_STOP] | ~sb_lvl_reg;  // R14 R15

    // signed limit comparisons on stored results
    wire c_loc_over = $signed(loc_reg) > $signed(lim_reg[0]);  // R20 R22
    wire c_loc_und  = $signed(loc_reg) < $signed(lim_reg[1]);  // R20 R22
    wire c_rem_over = $signed(rem_reg) > $signed(lim_reg[2]);  // R20 R22
    wire c_rem_und  = $signed(rem_reg) < $signed(lim_reg[3]);  // R20 R22
    wire [4:0] cond = {c_loc_over, c_loc_und, c_rem_over,
                       c_rem_und, open_reg};

    // period = fastest period shifted by the unused rate steps
    wire [2:0]  rate_shift = tmrb_pkg::RATE_MAX_CODE - rate_reg[2:0];
    wire [31:0] period_cyc = FAST_PERIOD_CYC << rate_shift;    // R18

    wire idle      = (state_reg == tmrb_pkg::ST_IDLE);
    wire tick      = (timer_reg == 32'h0000_0000);
    // conversion launch: boot, periodic run, or one-shot
    wire start_conv = idle & ((boot_reg & ~standby)
                      | (~boot_reg & shot_pend_reg)
                      | (~boot_reg & tick & ~standby));        // R13 R14
    // booting in standby compares the stale defaults once
    wire boot_eval = idle & boot_reg & standby;
    // standby aborts a periodic pass so results stay frozen
    wire abort     = (state_reg == tmrb_pkg::ST_CONV)
                     & standby & ~shot_run_reg;                // R16
    wire take_res  = (state_reg == tmrb_pkg::ST_CONV)
                     & conv_done_i & ~abort;                   // R01
    wire eval      = (state_reg == tmrb_pkg::ST_EVAL);
    wire busy      = ~idle;                                    // R02

    // remote result with signed offset, wraps at eight bits
    wire [7:0] rem_adj = conv_res_i.remote_temp + ofs_reg;     // R26

    // ---------------------------------------------------------------
    // read selection; unknown or write-only addresses give zero
    // ---------------------------------------------------------------
    always_comb begin
        case (ptr_reg)
            tmrb_pkg::RD_LOCAL:  rd_mux = loc_reg;
            tmrb_pkg::RD_REMOTE: rd_mux = rem_reg;
            tmrb_pkg::RD_STATUS: rd_mux = {busy, flag_reg, 2'b00}; // R07
            tmrb_pkg::RD_CFG:    rd_mux = cfg_reg;
            tmrb_pkg::RD_RATE:   rd_mux = rate_reg;
            8'h05:               rd_mux = lim_reg[0];           // R12
            8'h06:               rd_mux = lim_reg[1];
            8'h07:               rd_mux = lim_reg[2];
            8'h08:               rd_mux = lim_reg[3];
            tmrb_pkg::ADDR_OFS:  rd_mux = ofs_reg;
            tmrb_pkg::RD_MAKER:  rd_mux = tmrb_pkg::MAKER_ID;
            tmrb_pkg::RD_REV:    rd_mux = tmrb_pkg::REV_ID;
            default:             rd_mux = 8'h00;                // R25 R27
        endcase
    end

    // ---------------------------------------------------------------
    // flag and latch updates; setting beats clearing
    // ---------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        // a read only drops flags whose cause has gone
        if (rd_status) begin
            flag_next = flag_reg & cond;                        // R09 R10
        end
        // comparisons land after each pass
        if (eval) begin
            flag_next = flag_next | cond;                       // R03 R04
        end
    end

    always_comb begin
        latch_next = latch_reg;
        // alert response clears only when all is quiet
        if (ara_i && (flag_reg == 5'h00) && (cond == 5'h00)) begin
            latch_next = 1'b0;                                  // R11
        end
        // any flag keeps the latch set
        if (|flag_reg) begin
            latch_next = 1'b1;                                  // R08
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        case (state_reg)
            tmrb_pkg::ST_IDLE: begin
                if (start_conv) begin
                    state_next = tmrb_pkg::ST_CONV;
                end else if (boot_eval) begin
                    state_next = tmrb_pkg::ST_EVAL;
                end else begin
                    state_next = tmrb_pkg::ST_IDLE;
                end
            end
            tmrb_pkg::ST_CONV: begin
                // abort wins over a late result
                if (abort) begin
                    state_next = tmrb_pkg::ST_IDLE;
                end else if (conv_done_i) begin
                    state_next = tmrb_pkg::ST_EVAL;
                end else begin
                    state_next = tmrb_pkg::ST_CONV;
                end
            end
            tmrb_pkg::ST_EVAL: state_next = tmrb_pkg::ST_IDLE;
            default:           state_next = tmrb_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= tmrb_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // period timer, reloaded at each launch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_reg <= 32'h0000_0000;
        end else if (start_conv) begin
            timer_reg <= period_cyc - 32'h0000_0001;            // R18
        end else if (!tick) begin
            timer_reg <= timer_reg - 32'h0000_0001;
        end
    end

    // boot, one-shot bookkeeping
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_reg      <= 1'b1;
            shot_pend_reg <= 1'b0;
            shot_run_reg  <= 1'b0;
        end else begin
            if (start_conv || boot_eval) begin
                boot_reg <= 1'b0;
            end
            // a new write is kept even while one is taken
            shot_pend_reg <= wr_shot
                             | (shot_pend_reg & ~start_conv);   // R13
            if (start_conv) begin
                shot_run_reg <= shot_pend_reg & ~boot_reg;
            end
        end
    end

    // ---------------------------------------------------------------
    // standby pin: three stages, change taken when 2 and 3 agree
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sb_s1_reg  <= 1'b1;
            sb_s2_reg  <= 1'b1;
            sb_s3_reg  <= 1'b1;
            sb_lvl_reg <= 1'b1;
        end else begin
            sb_s1_reg <= standby_pin_n_i;
            sb_s2_reg <= sb_s1_reg;
            sb_s3_reg <= sb_s2_reg;
            if (sb_s2_reg == sb_s3_reg) begin
                sb_lvl_reg <= sb_s3_reg;                        // R15
            end
        end
    end

    // ---------------------------------------------------------------
    // host registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_reg <= tmrb_pkg::PTR_RST;
        end else if (ptr_load) begin
            ptr_reg <= wr_data_i;                               // R23
        end
    end

    // only mask and run bits are kept, the rest read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= tmrb_pkg::CFG_RST;                       // R17
        end else if (wr_cfg) begin
            cfg_reg <= {wr_data_i[7:6], 6'h00};                 // R14 R17
        end
    end

    // upper bits stored as given; the host keeps them zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rate_reg <= tmrb_pkg::RATE_RST;                     // R21
        end else if (wr_rate) begin
            rate_reg <= wr_data_i;                              // R19
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ofs_reg <= tmrb_pkg::OFS_RST;                       // R26
        end else if (wr_ofs) begin
            ofs_reg <= wr_data_i;
        end
    end

    // four limits: even index high, odd index low
    for (genvar i = 0; i < 4; i++) begin : g_lim
        localparam logic [7:0] RST_V =
            (i % 2 == 0) ? tmrb_pkg::HI_RST : tmrb_pkg::LO_RST;
        wire hit = data_wr
                   & (ptr_reg == tmrb_pkg::WR_LIMIT0 + 8'(i));  // R12
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                lim_reg[i] <= RST_V;                            // R21
            end else if (hit) begin
                lim_reg[i] <= wr_data_i;                        // R22
            end
        end
    end

    // ---------------------------------------------------------------
    // results, written by the converter path alone
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            loc_reg  <= tmrb_pkg::TEMP_RST;                     // R21
            rem_reg  <= tmrb_pkg::TEMP_RST;
            open_reg <= 1'b0;
        end else if (take_res) begin
            loc_reg  <= conv_res_i.local_temp;                  // R01
            rem_reg  <= rem_adj;                                // R26
            open_reg <= conv_res_i.remote_open;                 // R07
        end
    end

    // flags and latch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_reg  <= 5'h00;
            latch_reg <= 1'b0;
        end else begin
            flag_reg  <= flag_next;                             // R05 R06
            latch_reg <= latch_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o    <= 8'h00;
            rd_valid_o   <= 1'b0;
            conv_start_o <= 1'b0;
            alert_n_o    <= 1'b1;
        end else begin
            rd_valid_o   <= rd_req_i;
            if (rd_req_i) begin
                rd_data_o <= rd_mux;                            // R02
            end
            conv_start_o <= start_conv;
            // mask hides current and future alerts
            alert_n_o <= ~(latch_next
                           & ~cfg_reg[tmrb_pkg::CFG_MASK]);     // R08 R17
        end
    end

endmodule : tmrb_core

// *** sim/tmrb_core_properties.sv ***
// port-level assertions for the register bank core
module tmrb_core_properties (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 wr_byte_i,
    input wire logic                 wr_first_i,
    input wire logic [7:0]           wr_data_i,
    input wire logic                 rd_req_i,
    input wire logic                 ara_i,
    input wire logic [7:0]           rd_data_o,
    input wire logic                 rd_valid_o,
    input wire logic                 conv_start_o,
    input wire logic                 conv_done_i,
    input wire tmrb_pkg::tmrb_conv_t conv_res_i,
    input wire logic                 standby_pin_n_i,
    input wire logic                 alert_n_o
);
    logic [7:0] ptr_reg;      // mirror of the address pointer
    logic [7:0] rptr_reg;     // pointer used by the last read
    logic       mask_reg;     // mirror of the alert mask bit
    logic [3:0] standby_pin_n_cnt_reg; // cycles the standby pin has been low
    logic       shot;         // one-shot write seen this cycle
    logic       cfg_wr;       // configuration data byte this cycle
    logic       stat_rd;      // status answer this cycle

    assign shot    = wr_byte_i && !wr_first_i && ptr_reg == 8'h0F;
    assign cfg_wr  = wr_byte_i && !wr_first_i && ptr_reg == 8'h09;
    assign stat_rd = rd_valid_o && rptr_reg == 8'h02;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // mirrors of the byte stream; saturating counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_reg      <= 8'h00;
            rptr_reg     <= 8'h00;
            mask_reg     <= 1'b0;
            standby_pin_n_cnt_reg <= 4'h0;
        end else begin
            ptr_reg      <= (wr_byte_i && wr_first_i) ? wr_data_i : ptr_reg;
            rptr_reg     <= rd_req_i ? ptr_reg : rptr_reg;
            mask_reg     <= cfg_wr ? wr_data_i[7] : mask_reg;
            standby_pin_n_cnt_reg <= standby_pin_n_i ? 4'h0 :
                            standby_pin_n_cnt_reg + {3'h0, standby_pin_n_cnt_reg != 4'hF};
        end
    end

    chk_read_answer: assert property (
        rd_valid_o == $past(rd_req_i)) else $error("read answer mistimed");
    chk_start_pulse: assert property (
        conv_start_o |=> !conv_start_o) else $error("start pulse too long");
    chk_standby_idle: assert property (
        conv_start_o && standby_pin_n_cnt_reg >= 4'h8 |->
        $past(shot) || $past(shot, 2) || $past(shot, 3) || $past(shot, 4))
        else $error("conversion started in pin standby");
    chk_alert_flag: assert property (
        stat_rd && |rd_data_o[6:2] && !mask_reg && !$past(mask_reg)
        |-> !alert_n_o) else $error("flag set but alert high");
    chk_mask_gate: assert property (
        mask_reg && $past(mask_reg) |-> alert_n_o)
        else $error("masked alert driven low");
    chk_status_rsvd: assert property (
        stat_rd |-> rd_data_o[1:0] == 2'b00)
        else $error("status low bits not zero");
    chk_unmapped_zero: assert property (
        rd_valid_o && (rptr_reg inside {[8'h09:8'h10]} ||
        rptr_reg inside {[8'h12:8'hFD]}) |-> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    chk_latch_hold: assert property (
        !alert_n_o && !ara_i && !mask_reg && !cfg_wr |=> !alert_n_o)
        else $error("alert released without response");
endmodule : tmrb_core_properties

bind tmrb_core tmrb_core_properties u_props (.clk_i, .rst_i, .wr_byte_i,
    .wr_first_i, .wr_data_i, .rd_req_i, .ara_i, .rd_data_o, .rd_valid_o,
    .conv_start_o, .conv_done_i, .conv_res_i, .standby_pin_n_i,
    .alert_n_o);

// *** sim/tmrb_conv_model.sv ***
// behavioural converter answering each start after a set delay
module tmrb_conv_model (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            conv_start_i,
    input  wire logic [7:0]      local_i,
    input  wire logic [7:0]      remote_i,
    input  wire logic            open_i,
    input  wire logic [7:0]      dly_i,
    output logic                 conv_done_o,
    output tmrb_pkg::tmrb_conv_t conv_res_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // one pass at a time; junk outside done; start seen mid-cycle
    initial begin
        conv_done_o = 1'b0;
        conv_res_o  = '1;
        forever begin
            @(negedge clk_i);
            if (!rst_i && conv_start_i) begin
                repeat (dly_i) @(negedge clk_i);
                conv_done_o = 1'b1;
                conv_res_o  = {local_i, remote_i, open_i};
                @(negedge clk_i);
                conv_done_o = 1'b0;
                conv_res_o  = ~conv_res_o;
            end
        end
    end
endmodule : tmrb_conv_model

// *** sim/temp_monitor_register_bank_tb_top.sv ***
// self-checking bench of the register bank core
module temp_monitor_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned FAST = 50; // shortened fastest period
    // reset reads: address, byte
    localparam logic [7:0] RA [15] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h08, 8'h11, 8'hFE, 8'hFF, 8'h10, 8'h0B, 8'h0F, 8'h12};
    localparam logic [7:0] RV [15] = '{8'h32, 8'h1E, 8'h00, 8'h02, 8'h7F,
        8'hC9, 8'h7F, 8'hC9, 8'h00, tmrb_pkg::MAKER_ID, tmrb_pkg::REV_ID,
        8'h00, 8'h00, 8'h00, 8'h00};
    // in-limit and just-tripping limits
    localparam logic [7:0] BASE [4] = '{8'h32, 8'hC9, 8'h1A, 8'h1A};
    localparam logic [7:0] TRIP [4] = '{8'h31, 8'h33, 8'h19, 8'h1B};

    logic                 clk_i, rst_i, wr_byte_i, wr_first_i, rd_req_i;
    logic                 ara_i, rd_valid_o, conv_start_o, conv_done_i;
    logic                 standby_pin_n_i, alert_n_o, opn;
    logic [7:0]           wr_data_i, rd_data_o, loc, rem, dly, bexp;
    tmrb_pkg::tmrb_conv_t conv_res_i;
    int                   num_errors, n_compared;

    tmrb_core #(.FAST_PERIOD_CYC(FAST)) DUT (.clk_i, .rst_i, .wr_byte_i,
        .wr_first_i, .wr_data_i, .rd_req_i, .ara_i, .rd_data_o, .rd_valid_o,
        .conv_start_o, .conv_done_i, .conv_res_i, .standby_pin_n_i,
        .alert_n_o);
    tmrb_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i),
        .conv_start_i(conv_start_o), .local_i(loc), .remote_i(rem),
        .open_i(opn), .dly_i(dly), .conv_done_o(conv_done_i),
        .conv_res_o(conv_res_i));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // pointer-only write: a single byte
    task automatic setp(input logic [7:0] p);
        @(negedge clk_i);
        wr_byte_i  = 1'b1;
        wr_first_i = 1'b1;
        wr_data_i  = p;
        @(negedge clk_i);
        wr_byte_i  = 1'b0;
        wr_first_i = 1'b0;
    endtask : setp

    // pointer byte then one data byte; alert settles a cycle later
    task automatic wr(input logic [7:0] p, d);
        setp(p);
        @(negedge clk_i);
        wr_byte_i = 1'b1;
        wr_data_i = d;
        @(negedge clk_i);
        wr_byte_i = 1'b0;
        @(negedge clk_i);
    endtask : wr

    // read one byte at p under mask m
    task automatic rd(input logic [7:0] p, exp, m, input string nm);
        setp(p);
        rd_req_i = 1'b1;
        @(negedge clk_i);
        rd_req_i = 1'b0;
        chk("rd_valid", {7'h00, rd_valid_o}, 8'h01);
        chk(nm, rd_data_o & m, exp);
    endtask : rd

    // alert response pulse
    task automatic ara;
        @(negedge clk_i);
        ara_i = 1'b1;
        @(negedge clk_i);
        ara_i = 1'b0;
        @(negedge clk_i);
    endtask : ara

    // all four limits, limit t tripping
    task automatic lims(input int t);
        for (int k = 0; k < 4; k++) begin
            wr(8'h0B + 8'(k), (k == t) ? TRIP[k] : BASE[k]);
            rd(8'h05 + 8'(k), (k == t) ? TRIP[k] : BASE[k], 8'hFF, "lim");
        end
    endtask : lims

    // hang guard
    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        $display("BAD watchdog expected end seen hang");
        stop_test();
    end

    initial begin
        rst_i = 1'b1;
        {wr_byte_i, wr_first_i, rd_req_i, ara_i, opn} = 5'h00;
        wr_data_i = 8'h00;
        standby_pin_n_i = 1'b1;
        loc = 8'h32;
        rem = 8'h1E;
        dly = 8'h0A;
        num_errors = 0;
        n_compared = 0;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        rd(8'h00, 8'h80, 8'hFF, "local_temp_value");
        repeat (30) @(negedge clk_i);
        for (int i = 0; i < 15; i++)
            rd(RA[i], RV[i], 8'hFF, "reset_table");
        $display("test reset done");
        // writes to read-only places dropped
        wr(8'h00, 8'h55);
        wr(8'h10, 8'h55);
        rd(8'h00, 8'h32, 8'hFF, "local_ro");
        rd(8'h10, 8'h00, 8'hFF, "reserved");
        wr(8'h09, 8'hBF);
        rd(8'h03, 8'h80, 8'hFF, "config");
        wr(8'h09, 8'h00);
        wr(8'h0A, 8'h07);
        rd(8'h04, 8'h07, 8'hFF, "rate");
        wr(8'h11, 8'hFC);
        rd(8'h11, 8'hFC, 8'hFF, "offset");
        wr(8'h0F, 8'h5A); // one-shot also restarts the period timer
        repeat (130) @(negedge clk_i);
        rd(8'h01, 8'h1A, 8'hFF, "remote_offset");
        $display("test access done");
        for (int i = 0; i < 5; i++) begin
            lims(i);
            opn = (i == 4);
            bexp = 8'h40 >> i;
            repeat (130) @(negedge clk_i);
            rd(8'h02, bexp, 8'h7F, "flag_set");
            rd(8'h02, bexp, 8'h7F, "flag_held");
            chk("alert", 8'(alert_n_o), 8'h00);
            ara();
            chk("alert_refused", 8'(alert_n_o), 8'h00);
            wr(8'h09, 8'h80);
            chk("alert_masked", 8'(alert_n_o), 8'h01);
            wr(8'h09, 8'h00);
            chk("alert_unmasked", 8'(alert_n_o), 8'h00);
            lims(4);
            opn = 1'b0;
            repeat (130) @(negedge clk_i);
            rd(8'h02, bexp, 8'h7F, "flag_stale");
            rd(8'h02, 8'h00, 8'h7F, "flag_clear");
            chk("latch_kept", 8'(alert_n_o), 8'h00);
            ara();
            chk("latch_clear", 8'(alert_n_o), 8'h01);
        end
        $display("test flags done");
        wr(8'h09, 8'h40);
        loc = 8'h3C;
        repeat (150) @(negedge clk_i);
        rd(8'h00, 8'h32, 8'hFF, "standby_hold");
        dly = 8'h1E;
        wr(8'h0F, 8'hA5);
        repeat (60) @(negedge clk_i);
        rd(8'h00, 8'h3C, 8'hFF, "one_shot");
        standby_pin_n_i = 1'b0;
        repeat (8) @(negedge clk_i);
        wr(8'h09, 8'h00);
        loc = 8'h46;
        repeat (150) @(negedge clk_i);
        rd(8'h00, 8'h3C, 8'hFF, "pin_standby");
        standby_pin_n_i = 1'b1;
        repeat (150) @(negedge clk_i);
        rd(8'h00, 8'h46, 8'hFF, "run_again");
        $display("test standby done");
        stop_test();
    end
endmodule : temp_monitor_register_bank_tb_top
